// file: rtl/bit_clock_if.sv
/*
 * Carrier between the port core and its bit rate generator.
 * Assumes both ends sit on sys_clk.
 */
interface bit_clock_if;
	logic [1:0] rate;
	logic tick;
	modport gen (input rate, output tick);
	modport user (output rate, input tick);
endinterface

// file: rtl/bit_rate_gen.sv
/*
 * Oversample tick generator: one pulse every rate_div(rate) enabled cycles.
 * Assumes a synchronised reset and the shared clock enable.
 */
module bit_rate_gen
	import serial_port_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ce,
	bit_clock_if.gen bclk
);
	logic [DIV_W-1:0] cnt;
	logic [DIV_W-1:0] next_cnt;
	logic tick;
	logic next_tick;

	// >= rather than == so a rate change never strands the counter
	always_comb
	begin
		next_cnt = cnt + DIV_W'(1);
		next_tick = 1'b0;
		if (cnt >= rate_div(bclk.rate) - DIV_W'(1))
		begin
			next_cnt = '0;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= '0;
			tick <= 1'b0;
		end
		else if (ce)
		begin
			cnt <= next_cnt;
			tick <= next_tick;
		end
	end

	assign bclk.tick = tick;

	// tick spacing follows the selected rate exactly while the rate code is steady; a raised rate can cut one period short
	a_tick_period: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ce && cnt == '0 && $past(cnt) == rate_div(bclk.rate) - DIV_W'(1)
		|-> tick)
		else $error("oversample tick missing at divisor end");
endmodule

// file: rtl/serial_port.sv
/*
 * 8N1 asynchronous serial port with an AXI4-Lite register slave,
 * sticky status with mask and one level interrupt.
 * Assumes txd/rxd reach the line through level shifters and that
 * the partner is set to the same rate; no other line takes part.
 */
// Implementation choices: the address map and the AXI4-Lite slave port.
// How it works
// - the rate code picks one of 9600, 19200, 38400 or 115200 bit/s and both directions time their bits from it.
// - after reset the rate code is 9600 bit/s until software writes another.
// - every character is eight data bits, no parity, one stop bit, with no flow control.
// - only the transmit and receive lines carry traffic, with no handshake.
// - the terminal ready and request to send outputs are held asserted at all times.
// - carrier, set ready, clear to send and ring inputs are ignored.
// - overrun, break and framing errors each set their own status bit; the parity bit is never set.
module serial_port
	import serial_port_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic txd,
	input wire logic rxd,
	output logic dtr,
	output logic rts,
	input wire logic dcd,
	input wire logic dsr,
	input wire logic cts,
	input wire logic ri,
	output logic irq
);
	typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} tx_state_e;
	typedef enum logic [3:0] {RX_IDLE = 4'b0001, RX_START = 4'b0010,
		RX_DATA = 4'b0100, RX_STOP = 4'b1000} rx_state_e;

	logic rst_q1, rst_n;
	logic rx_s1, rx_s2, rx_s3, rx_level, rx_prev, next_rx_level;
	logic aw_got, w_got, next_aw_got, next_w_got;
	logic [ADDR_W-1:0] aw_q, next_aw_q;
	logic [7:0] wd_q, next_wd_q;
	logic ws_q, next_ws_q;
	logic next_awready, next_wready, next_arready, next_bvalid, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic [1:0] ctrl_rate, next_ctrl_rate;
	logic [ST_W-1:0] status, next_status, mask, next_mask, ev;
	logic rd_status, rd_rx, wr_tx, next_irq;
	tx_state_e tx_state, next_tx_state;
	logic [8:0] tx_shift, next_tx_shift;
	logic [3:0] tx_cnt, next_tx_cnt, tx_bits, next_tx_bits;
	logic next_txd, tx_done;
	rx_state_e rx_state, next_rx_state;
	logic [3:0] rx_cnt, next_rx_cnt;
	logic [2:0] rx_bits, next_rx_bits;
	logic [7:0] rx_shift, next_rx_shift, rx_data, next_rx_data;
	logic rx_full, next_rx_full, rx_done, rx_stop_bad;

	bit_clock_if bclk ();

	bit_rate_gen u_rate (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.ce(ce),
		.bclk(bclk)
	);
	assign bclk.rate = ctrl_rate;

	// reset release through two flops; assertion is immediate
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end
		else if (ce)
		begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	// rxd is foreign: three flops, a change counts once s2 and s3 agree
	always_comb
	begin
		next_rx_level = rx_level;
		if (rx_s2 == rx_s3)
			next_rx_level = rx_s3;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			rx_s3 <= 1'b1;
			rx_level <= 1'b1;
			rx_prev <= 1'b1;
		end
		else if (ce)
		begin
			rx_s1 <= rxd;
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
			rx_level <= next_rx_level;
			rx_prev <= rx_level;
		end
	end

	// bus slave: address and data taken in either order, one at a time
	always_comb
	begin
		next_aw_got = aw_got;
		next_w_got = w_got;
		next_aw_q = aw_q;
		next_wd_q = wd_q;
		next_ws_q = ws_q;
		next_bvalid = s_axi_bvalid && !s_axi_bready;
		next_bresp = s_axi_bresp;
		next_rvalid = s_axi_rvalid && !s_axi_rready;
		next_rresp = s_axi_rresp;
		next_rdata = s_axi_rdata;
		next_ctrl_rate = ctrl_rate;
		next_mask = mask;
		rd_status = 1'b0;
		rd_rx = 1'b0;
		wr_tx = 1'b0;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_got = 1'b1;
			next_aw_q = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_got = 1'b1;
			next_wd_q = s_axi_wdata[7:0];
			next_ws_q = s_axi_wstrb[0];
		end
		if (aw_got && w_got && !s_axi_bvalid)
		begin
			next_aw_got = 1'b0;
			next_w_got = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = RESP_OKAY;
			case ({aw_q[ADDR_W-1:2], 2'b00})
				REG_CTRL: if (ws_q) next_ctrl_rate = wd_q[1:0];
				REG_MASK: if (ws_q) next_mask = wd_q[ST_W-1:0];
				REG_TXDATA: wr_tx = ws_q; // dropped while busy
				REG_STATUS, REG_RXDATA, REG_LINE: ;
				default: next_bresp = RESP_SLVERR;
			endcase
		end
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_rvalid = 1'b1;
			next_rresp = RESP_OKAY;
			next_rdata = '0;
			case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
				REG_CTRL: next_rdata[1:0] = ctrl_rate;
				REG_STATUS:
				begin
					next_rdata[ST_W-1:0] = status;
					rd_status = 1'b1;
				end
				REG_MASK: next_rdata[ST_W-1:0] = mask;
				REG_TXDATA: next_rdata[LN_TX_BUSY] = tx_state == TX_SEND;
				REG_RXDATA:
				begin
					next_rdata[7:0] = rx_data;
					rd_rx = 1'b1;
				end
				REG_LINE:
				begin
					next_rdata[LN_TX_BUSY] = tx_state == TX_SEND;
					next_rdata[LN_RX_FULL] = rx_full;
				end
				default: next_rresp = RESP_SLVERR;
			endcase
		end
		next_awready = !next_aw_got && !next_bvalid;
		next_wready = !next_w_got && !next_bvalid;
		next_arready = !next_rvalid;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_q <= '0;
			wd_q <= '0;
			ws_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= '0;
			ctrl_rate <= RATE_RESET;
			mask <= '0;
		end
		else if (ce)
		begin
			aw_got <= next_aw_got;
			w_got <= next_w_got;
			aw_q <= next_aw_q;
			wd_q <= next_wd_q;
			ws_q <= next_ws_q;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_arready <= next_arready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rresp <= next_rresp;
			s_axi_rdata <= next_rdata;
			ctrl_rate <= next_ctrl_rate;
			mask <= next_mask;
		end
	end

	// transmitter: start, 8 data lsb first, stop; never gated
	always_comb
	begin
		next_tx_state = tx_state;
		next_tx_shift = tx_shift;
		next_tx_cnt = tx_cnt;
		next_tx_bits = tx_bits;
		next_txd = txd;
		tx_done = 1'b0;
		case (tx_state)
			TX_IDLE:
			begin
				next_txd = 1'b1;
				if (wr_tx)
				begin
					next_txd = 1'b0;
					next_tx_shift = {1'b1, wd_q};
					next_tx_cnt = '0;
					next_tx_bits = '0;
					next_tx_state = TX_SEND;
				end
			end
			TX_SEND:
				if (bclk.tick)
				begin
					next_tx_cnt = tx_cnt + 4'h1;
					if (tx_cnt == TICK_LAST)
					begin
						if (tx_bits == LAST_FRAME_BIT)
						begin
							tx_done = 1'b1;
							next_tx_state = TX_IDLE;
						end
						else
						begin
							next_txd = tx_shift[0];
							next_tx_shift = {1'b1, tx_shift[8:1]};
							next_tx_bits = tx_bits + 4'h1;
						end
					end
				end
			default: next_tx_state = TX_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_state <= TX_IDLE;
			tx_shift <= '1;
			tx_cnt <= '0;
			tx_bits <= '0;
			txd <= 1'b1;
			dtr <= 1'b1;
			rts <= 1'b1;
		end
		else if (ce)
		begin
			tx_state <= next_tx_state;
			tx_shift <= next_tx_shift;
			tx_cnt <= next_tx_cnt;
			tx_bits <= next_tx_bits;
			txd <= next_txd;
			dtr <= 1'b1;
			rts <= 1'b1;
		end
	end

	// receiver: falling edge starts, mid-bit sampling at 16x
	always_comb
	begin
		next_rx_state = rx_state;
		next_rx_cnt = rx_cnt;
		next_rx_bits = rx_bits;
		next_rx_shift = rx_shift;
		rx_done = 1'b0;
		rx_stop_bad = 1'b0;
		case (rx_state)
			RX_IDLE:
				if (rx_prev && !rx_level)
				begin
					next_rx_cnt = '0;
					next_rx_state = RX_START;
				end
			RX_START:
				if (bclk.tick)
				begin
					next_rx_cnt = rx_cnt + 4'h1;
					if (rx_cnt == TICK_MID)
					begin
						next_rx_cnt = '0;
						next_rx_bits = '0;
						// a glitch shorter than half a bit is not a start
						next_rx_state = rx_level ? RX_IDLE : RX_DATA;
					end
				end
			RX_DATA:
				if (bclk.tick)
				begin
					next_rx_cnt = rx_cnt + 4'h1;
					if (rx_cnt == TICK_LAST)
					begin
						next_rx_shift = {rx_level, rx_shift[7:1]};
						next_rx_bits = rx_bits + 3'h1;
						if (rx_bits == LAST_DATA_BIT)
							next_rx_state = RX_STOP;
					end
				end
			RX_STOP:
				if (bclk.tick)
				begin
					next_rx_cnt = rx_cnt + 4'h1;
					if (rx_cnt == TICK_LAST)
					begin
						rx_done = 1'b1;
						rx_stop_bad = !rx_level;
						next_rx_state = RX_IDLE;
					end
				end
			default: next_rx_state = RX_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_state <= RX_IDLE;
			rx_cnt <= '0;
			rx_bits <= '0;
			rx_shift <= '0;
		end
		else if (ce)
		begin
			rx_state <= next_rx_state;
			rx_cnt <= next_rx_cnt;
			rx_bits <= next_rx_bits;
			rx_shift <= next_rx_shift;
		end
	end

	// events; with no parity bit on the line that flag cannot fire
	always_comb
	begin
		ev = '0;
		ev[ST_RX_READY] = rx_done;
		ev[ST_TX_DONE] = tx_done;
		ev[ST_OVERRUN] = rx_done && rx_full && !rd_rx;
		ev[ST_BREAK] = rx_done && rx_stop_bad && rx_shift == '0;
		ev[ST_FRAMING] = rx_done && rx_stop_bad && rx_shift != '0;
		ev[ST_PARITY] = 1'b0;
		next_status = (rd_status ? '0 : status) | ev; // set beats clear
		next_rx_full = rx_done || (rx_full && !rd_rx);
		next_rx_data = rx_data;
		if (rx_done && (!rx_full || rd_rx))
			next_rx_data = rx_shift; // an overrun keeps the older byte
		next_irq = |(next_status & mask);
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status <= '0;
			rx_full <= 1'b0;
			rx_data <= '0;
			irq <= 1'b0;
		end
		else if (ce)
		begin
			status <= next_status;
			rx_full <= next_rx_full;
			rx_data <= next_rx_data;
			irq <= next_irq;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_rate_default: assert property ($rose(rst_n) |-> ctrl_rate == RATE_9600)
		else $error("rate code not 9600 after reset");
	a_start_bit_low: assert property ($rose(tx_state == TX_SEND) |-> !txd)
		else $error("frame does not open with a low start bit");
	a_idle_high: assert property (tx_state == TX_IDLE |-> txd)
		else $error("line not high while idle");
	a_frame_length: assert property ($fell(tx_state == TX_SEND)
		|-> $past(tx_bits) == LAST_FRAME_BIT && txd)
		else $error("frame not ten bits ending high");
	a_txd_quiet: assert property (ce && tx_state == TX_IDLE && !wr_tx
		|=> txd)
		else $error("txd moved without a frame");
	a_flow_lines: assert property (dtr && rts ##1 dtr && rts)
		else $error("dtr or rts deasserted");
	a_overrun_flag: assert property (ce && rx_done && rx_full && !rd_rx
		|=> status[ST_OVERRUN])
		else $error("lost character not flagged");
	a_framing_flag: assert property (ce && rx_done && !rx_level
		|=> status[ST_BREAK] || status[ST_FRAMING])
		else $error("bad stop bit not flagged");
	a_rx_sample: assert property (ce && rx_state == RX_STOP && bclk.tick
		&& rx_cnt == TICK_LAST |=> rx_state == RX_IDLE && rx_full)
		else $error("receiver did not close frame after stop bit");

	c_tx_frame: cover property ($fell(tx_state == TX_SEND));
	c_rx_good: cover property (rx_done && rx_level && !rx_full);
	c_overrun: cover property (ev[ST_OVERRUN]);
	c_break: cover property (ev[ST_BREAK]);
	c_fast_rate: cover property (ctrl_rate == RATE_115200 && rx_done);
endmodule

// file: rtl/serial_port_pkg.sv
/*
 * Shared constants for the 8N1 serial port: register map, status layout,
 * bit rate codes and divisor table, frame shape and bus responses.
 * Assumes a 40 MHz system clock and a 16x oversampled bit clock.
 */
package serial_port_pkg;

	// register map, byte addresses on the AXI4-Lite bus
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 5'h04;
	localparam logic [ADDR_W-1:0] REG_MASK = 5'h08;
	localparam logic [ADDR_W-1:0] REG_TXDATA = 5'h0c;
	localparam logic [ADDR_W-1:0] REG_RXDATA = 5'h10;
	localparam logic [ADDR_W-1:0] REG_LINE = 5'h14;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// bit rate codes held in the control register
	localparam logic [1:0] RATE_9600 = 2'h0;
	localparam logic [1:0] RATE_19200 = 2'h1;
	localparam logic [1:0] RATE_38400 = 2'h2;
	localparam logic [1:0] RATE_115200 = 2'h3;
	localparam logic [1:0] RATE_RESET = RATE_9600;

	// timing: clock rate, oversampling, bit rates in bits per second
	localparam int CLK_HZ = 40_000_000;
	localparam int OVERSAMPLE = 16;
	localparam int BPS_9600 = 9600;
	localparam int BPS_19200 = 19200;
	localparam int BPS_38400 = 38400;
	localparam int BPS_115200 = 115200;
	localparam int DIV_W = 9;

	// status bits, sticky, cleared by a read of the status register
	localparam int ST_W = 6;
	localparam int ST_RX_READY = 0;
	localparam int ST_TX_DONE = 1;
	localparam int ST_OVERRUN = 2;
	localparam int ST_BREAK = 3;
	localparam int ST_PARITY = 4;
	localparam int ST_FRAMING = 5;

	// frame shape: start, eight data bits, one stop bit
	localparam int DATA_BITS = 8;
	localparam logic [2:0] LAST_DATA_BIT = 3'h7;
	localparam logic [3:0] LAST_FRAME_BIT = 4'h9;
	localparam logic [3:0] TICK_MID = 4'h7;
	localparam logic [3:0] TICK_LAST = 4'hf;

	// line status bits
	localparam int LN_TX_BUSY = 0;
	localparam int LN_RX_FULL = 1;

	// oversample divisor for a rate code, rounded to the nearest cycle
	function automatic logic [DIV_W-1:0] rate_div(input logic [1:0] sel);
		int bps;
		case (sel)
			RATE_19200: bps = BPS_19200;
			RATE_38400: bps = BPS_38400;
			RATE_115200: bps = BPS_115200;
			default: bps = BPS_9600;
		endcase
		rate_div = DIV_W'((CLK_HZ + bps * OVERSAMPLE / 2)
			/ (bps * OVERSAMPLE));
	endfunction

endpackage

// file: tb/serial_partner.sv
/*
 * Behavioural far-end controller on the serial line, 8N1.
 * Assumes its bit time BIT_NS matches the rate chosen in the port.
 */
module serial_partner #(
	parameter int BIT_NS = 8800
) (
	input wire logic line_in,
	output logic line_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] last_char;
	logic stop_ok;
	int rx_count;

	// idle high, rate fixed by hand, no autobaud
	initial
	begin
		line_out = 1'b1;
		rx_count = 0;
	end

	// start low, data lsb first, stop level, no flow control
	task automatic send_char(input logic [7:0] d, input logic stop);
		// keep every line change clear of the sampling edge
		#3;
		line_out = 1'b0;
		#(BIT_NS);
		for (int i = 0; i < 8; i++)
		begin
			line_out = d[i];
			#(BIT_NS);
		end
		line_out = stop;
		#(BIT_NS);
		line_out = 1'b1;
		#(BIT_NS);
	endtask

	// mid-bit sampling after each start edge
	always
	begin
		@(negedge line_in);
		#(BIT_NS / 2);
		for (int i = 0; i < 8; i++)
		begin
			#(BIT_NS);
			last_char[i] = line_in;
		end
		#(BIT_NS);
		stop_ok = line_in;
		rx_count++;
	end
endmodule

// file: tb/tb_instrument_serial_port_8n1.sv
/*
 * Self-checking bench for the 8N1 serial port: register rows, then
 * transmit, receive, line errors and bit timing by hand.
 * Assumes the partner model on txd/rxd runs at 115200 bit/s.
 */
module tb_instrument_serial_port_8n1
	import serial_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic wr;
		logic [4:0] a;
		logic [31:0] d;
		logic [31:0] exp;
		logic [1:0] resp;
	} row_s;
	logic sys_clk = 1'b0, reset_n = 1'b0, ce = 1'b1;
	logic [4:0] s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic dcd = 1'b0, dsr = 1'b0, cts = 1'b1, ri = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, txd, rxd, dtr, rts, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	int compares = 0, miscompares = 0, n, c, len, dv;
	// oversample divisors per rate code at 40 MHz, nearest cycle
	int div_tab[4] = '{260, 130, 65, 22};
	row_s rows[10] = '{
		'{1'b1, REG_CTRL, 32'h1, 32'h0, RESP_OKAY},
		'{1'b0, REG_CTRL, 32'h0, 32'h1, RESP_OKAY},
		'{1'b1, REG_CTRL, 32'hffff_fffe, 32'h0, RESP_OKAY},
		'{1'b0, REG_CTRL, 32'h0, 32'h2, RESP_OKAY},
		'{1'b1, REG_MASK, 32'hffff_ffff, 32'h0, RESP_OKAY},
		'{1'b0, REG_MASK, 32'h0, 32'h3f, RESP_OKAY},
		'{1'b0, REG_LINE, 32'h0, 32'h0, RESP_OKAY},
		'{1'b0, 5'h18, 32'h0, 32'h0, RESP_SLVERR},
		'{1'b1, 5'h1c, 32'h7, 32'h0, RESP_SLVERR},
		'{1'b1, REG_MASK, 32'h0, 32'h0, RESP_OKAY}};

	serial_port dut (.sys_clk(sys_clk), .reset_n(reset_n), .ce(ce),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .txd(txd), .rxd(rxd), .dtr(dtr),
		.rts(rts), .dcd(dcd), .dsr(dsr), .cts(cts), .ri(ri), .irq(irq));
	serial_partner #(.BIT_NS(16 * 22 * 25)) partner (.line_in(txd),
		.line_out(rxd));

	// 40 MHz system clock
	always #12.5 sys_clk = ~sys_clk;

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// waits as long as the slave needs; only the watchdog ends a hang
	task automatic axi_write(input logic [4:0] a, input logic [31:0] wd,
		output logic [1:0] rs);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= wd;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [4:0] a, output logic [31:0] rd,
		output logic [1:0] rs);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic wait_irq();
		for (n = 0; n < 30000 && irq !== 1'b1; n++) @(posedge sys_clk);
	endtask

	task automatic final_report();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// main sequence
	initial
	begin
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		check("dtr", dtr, 1'b1);
		check("rts", rts, 1'b1);
		check("txd idle", txd, 1'b1);
		check("irq", irq, 1'b0);
		axi_read(REG_CTRL, d, r);
		check("ctrl reset", d, {30'h0, RATE_RESET});
		$display("test reset done");
		// rate codes, masks, line status and bad addresses through the table
		foreach (rows[i])
		begin
			if (rows[i].wr) axi_write(rows[i].a, rows[i].d, r);
			else axi_read(rows[i].a, d, r);
			if (!rows[i].wr) check("rdata", d, rows[i].exp);
			check("resp", r, rows[i].resp);
		end
		$display("test register rows done");
		// transmit with modem lines set so as to block if honoured
		axi_write(REG_CTRL, {30'h0, RATE_115200}, r);
		axi_write(REG_MASK, 32'h1 << ST_TX_DONE, r);
		dcd <= 1'b1;
		dsr <= 1'b1;
		cts <= 1'b0;
		ri <= 1'b1;
		c = partner.rx_count;
		axi_write(REG_TXDATA, 32'ha6, r);
		axi_write(REG_TXDATA, 32'h5a, r);
		check("busy write resp", r, RESP_OKAY);
		axi_read(REG_LINE, d, r);
		check("tx busy", d[0], 1'b1);
		wait_irq();
		check("irq tx done", irq, 1'b1);
		check("tx char", partner.last_char, 8'ha6);
		check("stop bit", partner.stop_ok, 1'b1);
		check("frames", partner.rx_count, c + 1);
		axi_read(REG_LINE, d, r);
		check("dropped write", d, 32'h0);
		axi_read(REG_STATUS, d, r);
		check("status tx", d, 32'h1 << ST_TX_DONE);
		repeat (3) @(posedge sys_clk);
		check("irq cleared", irq, 1'b0);
		check("dtr held", dtr & rts, 1'b1);
		$display("test transmit done");
		// receive one good character
		axi_write(REG_MASK, 32'h1 << ST_RX_READY, r);
		partner.send_char(8'h3c, 1'b1);
		wait_irq();
		check("irq rx", irq, 1'b1);
		axi_read(REG_STATUS, d, r);
		check("status rx", d, 32'h1);
		axi_read(REG_RXDATA, d, r);
		check("rx char", d, 32'h3c);
		$display("test receive done");
		// framing then break, each in its own bit, parity never
		partner.send_char(8'h81, 1'b0);
		axi_read(REG_STATUS, d, r);
		check("framing", d[ST_FRAMING], 1'b1);
		check("break clear", d[ST_BREAK], 1'b0);
		axi_read(REG_RXDATA, d, r);
		partner.send_char(8'h00, 1'b0);
		axi_read(REG_STATUS, d, r);
		check("break", d[ST_BREAK], 1'b1);
		check("parity", d[ST_PARITY], 1'b0);
		axi_read(REG_RXDATA, d, r);
		// second byte lands on an unread one
		partner.send_char(8'h11, 1'b1);
		partner.send_char(8'h22, 1'b1);
		axi_read(REG_STATUS, d, r);
		check("overrun", d[ST_OVERRUN], 1'b1);
		axi_read(REG_RXDATA, d, r);
		check("older byte kept", d, 32'h11);
		$display("test line errors done");
		// 9600 is skipped: one frame alone would take 41600 cycles
		axi_write(REG_MASK, 32'h1 << ST_TX_DONE, r);
		for (int k = 3; k >= 1; k--)
		begin
			axi_write(REG_CTRL, k, r);
			axi_write(REG_TXDATA, 32'hfe, r);
			dv = div_tab[k];
			for (n = 0; n < 3000 && txd !== 1'b0; n++) @(posedge sys_clk);
			for (len = 0; len < 9000 && txd === 1'b0; len++)
				@(posedge sys_clk);
			// start plus d0 low: 32 ticks, first may lose one tick
			check("bit time", len >= 31 * dv && len <= 32 * dv + 1, 1'b1);
			wait_irq();
			axi_read(REG_STATUS, d, r);
		end
		$display("test bit rates done");
		// mid-run reset with ce low: release waits for ce, rate back to 9600
		reset_n <= 1'b0;
		@(posedge sys_clk);
		reset_n <= 1'b1;
		ce <= 1'b0;
		repeat (4) @(posedge sys_clk);
		check("frozen ready", s_axi_arready, 1'b0);
		ce <= 1'b1;
		axi_read(REG_CTRL, d, r);
		check("ctrl mid reset", d, {30'h0, RATE_RESET});
		// a write with the low strobe bit clear changes nothing
		s_axi_wstrb <= 4'he;
		axi_write(REG_CTRL, {30'h0, RATE_115200}, r);
		s_axi_wstrb <= 4'hf;
		check("strobe resp", r, RESP_OKAY);
		axi_read(REG_CTRL, d, r);
		check("strobe off", d, {30'h0, RATE_RESET});
		$display("test mid reset done");
		final_report();
	end

	// hang guard, well above the expected 60000 cycles
	initial
	begin
		repeat (95000) @(posedge sys_clk);
		miscompares++;
		final_report();
	end
endmodule
